// ===== eam_mailbox.sv
// Extended access mailbox: register set, write and read engines
`timescale 1ns/1ps
module eam_mailbox
  import eam_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  output eam_req_t         proc_wr,
  input  wire logic        proc_wr_done,
  input  wire logic        proc_wr_nvm,
  input  wire logic        proc_prog_done,
  output eam_req_t         proc_rd,
  input  wire logic        proc_rd_done,
  input  wire logic [31:0] proc_rd_data,
  output eam_cmd_t         cmd_pulse
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic wr_target_we;
  logic wr_pay_hi_we;
  logic wr_pay_lo_we;
  logic wr_ctrl_we;
  logic rd_target_we;
  logic rd_ctrl_we;
  logic rd_pay_hi_we;
  logic rd_pay_lo_we;
  logic cmd_we;

  // Word write strobes
  assign wr_target_we = reg_wr && hit(reg_addr, OFF_WR_TARGET);
  assign wr_pay_hi_we = reg_wr && hit(reg_addr, OFF_WR_PAY_HI);
  assign wr_pay_lo_we = reg_wr && hit(reg_addr, OFF_WR_PAY_LO);
  assign wr_ctrl_we   = reg_wr && hit(reg_addr, OFF_WR_CTRL);
  assign rd_target_we = reg_wr && hit(reg_addr, OFF_RD_TARGET);
  assign rd_ctrl_we   = reg_wr && hit(reg_addr, OFF_RD_CTRL);
  assign rd_pay_hi_we = reg_wr && hit(reg_addr, OFF_RD_PAY_HI);
  assign rd_pay_lo_we = reg_wr && hit(reg_addr, OFF_RD_PAY_LO);
  assign cmd_we       = reg_wr && hit(reg_addr, OFF_CMD_WORD);

  // ----------------------------------------------------------------------
  // Plain storage registers
  // ----------------------------------------------------------------------
  logic [15:0] wr_target_q;
  logic [15:0] wr_target_d;
  logic [31:0] wr_pay_q;
  logic [31:0] wr_pay_d;
  logic [15:0] rd_target_q;
  logic [15:0] rd_target_d;
  logic [7:0]  func_q;
  logic [7:0]  func_d;

  // Next values of the master-written registers
  always_comb begin
    wr_target_d = wr_target_q;
    wr_pay_d    = wr_pay_q;
    rd_target_d = rd_target_q;
    func_d      = func_q;
    if (wr_target_we) begin
      wr_target_d = reg_wdata;
    end
    if (wr_pay_hi_we) begin
      wr_pay_d[31:16] = reg_wdata;
    end
    if (wr_pay_lo_we) begin
      wr_pay_d[15:0] = reg_wdata;
    end
    if (rd_target_we) begin
      rd_target_d[15:8] = reg_wdata[15:8];
      rd_target_d[7:0]  = reg_wdata[7:0];
    end
    if (cmd_we) begin
      func_d = reg_wdata[WORD_W-1:FUNC_LO] & FUNC_MASK;
    end
  end

  // Storage flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_target_q <= WORD_ZERO;
      wr_pay_q    <= DATA_ZERO;
      rd_target_q <= WORD_ZERO;
      func_q      <= BYTE_ZERO;
    end else begin
      wr_target_q <= wr_target_d;
      wr_pay_q    <= wr_pay_d;
      rd_target_q <= rd_target_d;
      func_q      <= func_d;
    end
  end

  // ----------------------------------------------------------------------
  // Write engine
  // ----------------------------------------------------------------------
  eam_wr_state_t wr_st_q;
  eam_wr_state_t wr_st_d;
  logic          wr_fin_q;
  logic          wr_fin_d;
  logic          wr_req_q;
  logic          wr_req_d;

  // Start on go, finish on completion or after programming pulses
  always_comb begin
    wr_st_d  = wr_st_q;
    wr_fin_d = wr_fin_q;
    wr_req_d = 1'b0;
    case (wr_st_q)
      WR_IDLE: begin
        if (wr_ctrl_we && reg_wdata[GO_BIT]) begin
          wr_st_d  = WR_BUSY;
          wr_fin_d = 1'b0;
          wr_req_d = 1'b1;
        end
      end
      WR_BUSY: begin
        if (proc_wr_done) begin
          if (proc_wr_nvm) begin
            wr_st_d = WR_PROG;
          end else begin
            wr_st_d  = WR_IDLE;
            wr_fin_d = 1'b1;
          end
        end
      end
      WR_PROG: begin
        if (proc_prog_done) begin
          wr_st_d  = WR_IDLE;
          wr_fin_d = 1'b1;
        end
      end
      default: begin
        wr_st_d = WR_IDLE;
      end
    endcase
  end

  // Write engine flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_st_q  <= WR_IDLE;
      wr_fin_q <= 1'b0;
      wr_req_q <= 1'b0;
    end else begin
      wr_st_q  <= wr_st_d;
      wr_fin_q <= wr_fin_d;
      wr_req_q <= wr_req_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read engine
  // ----------------------------------------------------------------------
  eam_rd_state_t rd_st_q;
  eam_rd_state_t rd_st_d;
  logic          rd_fin_q;
  logic          rd_fin_d;
  logic          rd_req_q;
  logic          rd_req_d;
  logic [31:0]   rd_pay_q;
  logic [31:0]   rd_pay_d;

  // Start on go, capture the fetched word on completion
  always_comb begin
    rd_st_d  = rd_st_q;
    rd_fin_d = rd_fin_q;
    rd_req_d = 1'b0;
    rd_pay_d = rd_pay_q;
    if (rd_pay_hi_we) begin
      rd_pay_d[31:16] = reg_wdata;
    end
    if (rd_pay_lo_we) begin
      rd_pay_d[15:0] = reg_wdata;
    end
    case (rd_st_q)
      RD_IDLE: begin
        if (rd_ctrl_we && reg_wdata[GO_BIT]) begin
          rd_st_d  = RD_BUSY;
          rd_fin_d = 1'b0;
          rd_req_d = 1'b1;
        end
      end
      RD_BUSY: begin
        if (proc_rd_done) begin
          rd_st_d  = RD_IDLE;
          rd_fin_d = 1'b1;
          rd_pay_d[15:0]  = proc_rd_data[15:0];
          rd_pay_d[31:16] = proc_rd_data[31:16];
        end
      end
      default: begin
        rd_st_d = RD_IDLE;
      end
    endcase
  end

  // Read engine flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_st_q  <= RD_IDLE;
      rd_fin_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_pay_q <= DATA_ZERO;
    end else begin
      rd_st_q  <= rd_st_d;
      rd_fin_q <= rd_fin_d;
      rd_req_q <= rd_req_d;
      rd_pay_q <= rd_pay_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        rvalid_q;
  logic        rvalid_d;

  // Read multiplexer; go bits and unmapped words read zero
  always_comb begin
    rdata_d  = WORD_ZERO;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        OFF_WR_TARGET: rdata_d = wr_target_q;
        OFF_WR_PAY_HI: rdata_d = wr_pay_q[31:16];
        OFF_WR_PAY_LO: rdata_d = wr_pay_q[15:0];
        OFF_WR_CTRL:   rdata_d[FINISHED_BIT] = wr_fin_q;
        OFF_RD_TARGET: rdata_d = rd_target_q;
        OFF_RD_CTRL:   rdata_d[FINISHED_BIT] = rd_fin_q;
        OFF_RD_PAY_HI: rdata_d = rd_pay_q[31:16];
        OFF_RD_PAY_LO: rdata_d = rd_pay_q[15:0];
        OFF_CMD_WORD:  rdata_d = {func_q, BYTE_ZERO};
        default:       rdata_d = WORD_ZERO;
      endcase
    end
  end

  // Read data flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q  <= WORD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------------
  // Command word decoder
  // ----------------------------------------------------------------------
  eam_cmd_decode u_cmd_decode (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_stb   (cmd_we),
    .wdata    (reg_wdata),
    .cmd      (cmd_pulse)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata     = rdata_q;
  assign reg_rvalid    = rvalid_q;
  assign proc_wr.req   = wr_req_q;
  assign proc_wr.addr  = wr_target_q;
  assign proc_wr.data  = wr_pay_q;
  assign proc_rd.req   = rd_req_q;
  assign proc_rd.addr  = rd_target_q;
  assign proc_rd.data  = DATA_ZERO;

endmodule

// ===== eam_pkg.sv
// Constants, types and register map of the extended access mailbox
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package eam_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------------
  // Register byte addresses (most significant byte of each word)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_WR_TARGET  = 8'h02;
  localparam logic [7:0] OFF_WR_PAY_HI  = 8'h04;
  localparam logic [7:0] OFF_WR_PAY_LO  = 8'h06;
  localparam logic [7:0] OFF_WR_CTRL    = 8'h08;
  localparam logic [7:0] OFF_RD_TARGET  = 8'h0A;
  localparam logic [7:0] OFF_RD_CTRL    = 8'h0C;
  localparam logic [7:0] OFF_RD_PAY_HI  = 8'h0E;
  localparam logic [7:0] OFF_RD_PAY_LO  = 8'h10;
  localparam logic [7:0] OFF_CMD_WORD   = 8'h1E;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GO_BIT       = 15;
  localparam int FINISHED_BIT = 0;
  localparam int STATE_HI     = 15;
  localparam int STATE_LO     = 14;
  localparam int FULL_RST_BIT = 13;
  localparam int PROC_RST_BIT = 12;
  localparam int CLR_STA_BIT  = 10;
  localparam int CLR_XERR_BIT = 9;
  localparam int CLR_ERR_BIT  = 8;
  localparam int KEY_HI       = 7;
  localparam int KEY_LO       = 0;
  localparam int FUNC_LO      = 8;

  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  KEY_STATE_CLEAR = 8'h46;
  localparam logic [7:0]  KEY_RESTART     = 8'hB9;
  localparam logic [1:0]  STATE_TO_IDLE   = 2'h2;
  localparam logic [1:0]  STATE_TO_RUN    = 2'h3;
  localparam logic [7:0]  FUNC_MASK       = 8'hF7;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [31:0] DATA_ZERO       = 32'h00000000;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // One-cycle command pulses towards the device core
  typedef struct packed {
    logic enter_idle;
    logic enter_run;
    logic full_restart;
    logic processor_restart;
    logic clear_status_flags;
    logic clear_extended_errors;
    logic clear_errors;
  } eam_cmd_t;

  // Request towards the internal processor
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic [31:0] data;
  } eam_req_t;

  // Write engine states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_BUSY = 2'b01,
    WR_PROG = 2'b10
  } eam_wr_state_t;

  // Read engine states
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_BUSY = 1'b1
  } eam_rd_state_t;

endpackage

// ===== eam_cmd_decode.sv
// Keycode-checked decoder of the command word into command pulses
`timescale 1ns/1ps
module eam_cmd_decode
  import eam_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        wr_stb,
  input  wire logic [15:0] wdata,
  output eam_cmd_t         cmd
);

  eam_cmd_t   cmd_d;
  eam_cmd_t   cmd_q;
  logic [7:0] key;
  logic       key_sc;
  logic       key_rs;

  // Unlock byte comparisons
  assign key    = wdata[KEY_HI:KEY_LO];
  assign key_sc = wr_stb && (key == KEY_STATE_CLEAR);
  assign key_rs = wr_stb && (key == KEY_RESTART);

  // Pulse only for the function written together with its code
  always_comb begin
    cmd_d = '0;
    cmd_d.enter_idle = key_sc &&
      (wdata[STATE_HI:STATE_LO] == STATE_TO_IDLE);
    cmd_d.enter_run = key_sc &&
      (wdata[STATE_HI:STATE_LO] == STATE_TO_RUN);
    cmd_d.clear_status_flags    = key_sc && wdata[CLR_STA_BIT];
    cmd_d.clear_extended_errors = key_sc && wdata[CLR_XERR_BIT];
    cmd_d.clear_errors          = key_sc && wdata[CLR_ERR_BIT];
    cmd_d.full_restart          = key_rs && wdata[FULL_RST_BIT];
    cmd_d.processor_restart     = key_rs && wdata[PROC_RST_BIT];
  end

  // Pulse register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  assign cmd = cmd_q;

endmodule

// ===== eam_mailbox_properties.sv
// Assertion checker bound to the mailbox top ports
`timescale 1ns/1ps
module eam_mailbox_properties
  import eam_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input eam_req_t         proc_wr,
  input eam_req_t         proc_rd,
  input eam_cmd_t         cmd_pulse
);
  // ----------------------------------------------------------------
  // Clocking and decoded writes
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic w_wc;
  logic w_rc;
  logic w_cw;
  // Writes to the two control words and the command word
  assign w_wc = reg_wr && reg_addr == OFF_WR_CTRL;
  assign w_rc = reg_wr && reg_addr == OFF_RD_CTRL;
  assign w_cw = reg_wr && reg_addr == OFF_CMD_WORD;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_wreq_cause: assert property (proc_wr.req |->
    $past(w_wc && reg_wdata[GO_BIT])) else $error("write req without go");
  a_wgo_zero: assert property (w_wc && !reg_wdata[GO_BIT] |=>
    !proc_wr.req) else $error("write req from go of zero");
  a_wreq_single: assert property (proc_wr.req |=>
    !proc_wr.req) else $error("write req not single");
  a_rreq_cause: assert property (proc_rd.req |->
    $past(w_rc && reg_wdata[GO_BIT])) else $error("read req without go");
  a_key_hidden: assert property (reg_rd && reg_addr == OFF_CMD_WORD |=>
    reg_rvalid && reg_rdata[7:0] == BYTE_ZERO) else $error("key visible");
  a_cmd_cause: assert property (cmd_pulse != 7'h00 |->
    $past(w_cw)) else $error("command pulse without write");
  a_state_key: assert property (cmd_pulse[6:5] != 2'h0 ||
    cmd_pulse[2:0] != 3'h0 |-> $past(reg_wdata[KEY_HI:KEY_LO]) ==
    KEY_STATE_CLEAR) else $error("state or clear without key");
  a_rst_key: assert property (cmd_pulse[4:3] != 2'h0 |->
    $past(reg_wdata[KEY_HI:KEY_LO]) == KEY_RESTART)
    else $error("restart without key");
  // Main scenarios reached
  c_wreq: cover property (proc_wr.req);
  c_rreq: cover property (proc_rd.req);
  c_full: cover property (cmd_pulse.full_restart);
endmodule
bind eam_mailbox eam_mailbox_properties eam_mailbox_properties_inst (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .proc_wr(proc_wr), .proc_rd(proc_rd), .cmd_pulse(cmd_pulse));

// ===== eam_proc_model.sv
// Behavioural model of the internal processor behind the mailbox
`timescale 1ns/1ps
module eam_proc_model
  import eam_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input eam_req_t         proc_wr,
  input eam_req_t         proc_rd,
  input wire logic [3:0]  lat,
  input wire logic        nvm,
  output logic            proc_wr_done,
  output logic            proc_wr_nvm,
  output logic            proc_prog_done,
  output logic            proc_rd_done,
  output logic [31:0]     proc_rd_data
);
  int          wc;
  int          pc;
  int          rc;
  logic [15:0] ra;
  // Counts each access down and answers with a one-cycle done
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wc <= 0;
      pc <= 0;
      rc <= 0;
      ra <= '0;
      {proc_wr_done, proc_wr_nvm, proc_prog_done, proc_rd_done} <= '0;
      proc_rd_data <= '0;
    end else begin
      wc <= proc_wr.req ? int'(lat) : (wc > 0 ? wc - 1 : 0);
      proc_wr_done <= wc == 1;
      proc_wr_nvm <= wc == 1 ? nvm : ~proc_wr_nvm;
      pc <= (wc == 1 && nvm) ? 8 : (pc > 0 ? pc - 1 : 0);
      proc_prog_done <= pc == 1;
      rc <= proc_rd.req ? int'(lat) : (rc > 0 ? rc - 1 : 0);
      if (proc_rd.req)
        ra <= proc_rd.addr;
      proc_rd_done <= rc == 1;
      // Data line shows a changing pattern outside the done cycle
      proc_rd_data <= rc == 1 ? {ra, ~ra} : ~proc_rd_data;
    end
  end
endmodule

// ===== eam_mailbox_tb.sv
// Self-checking testbench of the extended access mailbox
`timescale 1ns/1ps
module eam_mailbox_tb
  import eam_pkg::*;
;
  logic        core_clk, resetn, reg_wr, reg_rd, nvm, reg_rvalid;
  logic        proc_wr_done, proc_wr_nvm, proc_prog_done, proc_rd_done;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, wa, ra;
  logic [31:0] wd, proc_rd_data;
  logic [3:0]  lat;
  logic [23:0] e;
  eam_req_t    proc_wr, proc_rd;
  eam_cmd_t    cmd_pulse;
  logic [23:0] exp_q[$];
  int          fail_count, checks, n;
  logic [7:0]  offs [10] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
                             8'h0C, 8'h0E, 8'h10, 8'h1E, 8'h30};
  logic [15:0] cw [10] = '{16'h8046, 16'hC046, 16'h20B9, 16'h10B9,
                           16'h0446, 16'h0246, 16'h0146, 16'h80B9,
                           16'h2046, 16'h0847};
  logic [6:0]  cp [10] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02,
                           7'h01, 7'h00, 7'h00, 7'h00};

  eam_mailbox eam_mailbox_inst (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .proc_wr(proc_wr), .proc_wr_done(proc_wr_done),
    .proc_wr_nvm(proc_wr_nvm), .proc_prog_done(proc_prog_done),
    .proc_rd(proc_rd), .proc_rd_done(proc_rd_done),
    .proc_rd_data(proc_rd_data), .cmd_pulse(cmd_pulse));
  eam_proc_model eam_proc_model_inst (.core_clk(core_clk),
    .resetn(resetn), .proc_wr(proc_wr), .proc_rd(proc_rd), .lat(lat),
    .nvm(nvm), .proc_wr_done(proc_wr_done), .proc_wr_nvm(proc_wr_nvm),
    .proc_prog_done(proc_prog_done), .proc_rd_done(proc_rd_done),
    .proc_rd_data(proc_rd_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [47:0] x, logic [47:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read that notes its expected word for the monitor
  task automatic rd(logic [7:0] a, logic [15:0] x);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({a, x});
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // Bounded wait on write done, programming done or read done
  task automatic wt(int s);
    n = 0;
    while ((s == 0 ? proc_wr_done : s == 1 ? proc_prog_done :
            proc_rd_done) !== 1'b1 && n < 64) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 64)
      chk("done wait", 1, 0);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and monitor
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  // Takes the oldest note whenever read data appears; checks each request against the expected address and data
  always @(posedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      chk($sformatf("rdata at %h", e[23:16]), e[15:0], reg_rdata);
    end
    if (proc_wr.req === 1'b1)
      chk("write request", {wa, wd}, {proc_wr.addr, proc_wr.data});
    if (proc_rd.req === 1'b1) begin
      chk("read address", ra, proc_rd.addr);
      chk("read request data", 0, proc_rd.data);
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h82d6c1e5));
    {resetn, reg_wr, reg_rd, nvm} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    lat = 4'h3;
    {wa, wd, ra} = '0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 16'h0000);
    // Volatile then nonvolatile write
    for (int k = 0; k < 2; k++) begin
      wa = 16'($urandom);
      wd = $urandom;
      lat <= 4'(3 + $urandom_range(7));
      nvm <= k[0];
      wr(8'h02, wa);
      wr(8'h04, wd[31:16]);
      wr(8'h06, wd[15:0]);
      rd(8'h04, wd[31:16]);
      rd(8'h06, wd[15:0]);
      rd(8'h02, wa);
      wr(8'h08, 16'h7FFF);
      rd(8'h08, {15'h0, k[0]});
      wr(8'h08, 16'h8000);
      rd(8'h08, 16'h0000);
      wt(0);
      rd(8'h08, {15'h0, ~k[0]});
      if (k == 1) begin
        wt(1);
        rd(8'h08, 16'h0001);
      end
    end
    // Extended read
    ra = 16'($urandom);
    wr(8'h0A, ra);
    rd(8'h0A, ra);
    wr(8'h0C, 16'h0001);
    rd(8'h0C, 16'h0000);
    wr(8'h0C, 16'h8000);
    rd(8'h0C, 16'h0000);
    wt(2);
    rd(8'h0C, 16'h0001);
    rd(8'h0E, ra);
    rd(8'h10, ~ra);
    // Every command with its own key; enter idle and full restart also with a wrong one
    foreach (cw[i]) begin
      wr(8'h1E, cw[i]);
      @(posedge core_clk);
      chk("command pulse", cp[i], cmd_pulse);
      rd(8'h1E, {cw[i][15:12], 1'b0, cw[i][10:8], 8'h00});
    end
    repeat (4) @(posedge core_clk);
    chk("pending reads", 0, exp_q.size());
    summarize();
  end
endmodule
